// *** logic/gcsr_pkg.sv ***
/*
  Shared constants and carrier types for the gesture configuration and
  status register bank. Assumes an 8-bit register address space reached
  through the device's serial register port.
*/
package gcsr_pkg;

  // Register byte offsets
  localparam logic [7:0] GCSR_OFF_FIFO_PULSE   = 8'hB1;
  localparam logic [7:0] GCSR_OFF_FILTER       = 8'hB2;
  localparam logic [7:0] GCSR_OFF_SLEEP_STATUS = 8'hB3;
  localparam logic [7:0] GCSR_OFF_CONTROL      = 8'hBC;

  // Field positions
  localparam int GCSR_FIFO_LVL_LSB   = 6;
  localparam int GCSR_FIFO_LVL_MSB   = 7;
  localparam int GCSR_PULSE_LSB      = 0;
  localparam int GCSR_PULSE_MSB      = 5;
  localparam int GCSR_WIN_SIZE_BIT   = 5;
  localparam int GCSR_SMOOTH_EN_BIT  = 4;
  localparam int GCSR_SLEEP_FLAG_BIT = 1;
  localparam int GCSR_CLEAR_BIT      = 0;

  // Reset values
  localparam logic [1:0] GCSR_RST_FIFO_LVL  = 2'h0;
  localparam logic [5:0] GCSR_RST_PULSE     = 6'h00;
  localparam logic       GCSR_RST_WIN_SIZE  = 1'b0;
  localparam logic       GCSR_RST_SMOOTH_EN = 1'b0;

  // FIFO levels selected by the two-bit field
  localparam logic [4:0] GCSR_LVL_CODE0 = 5'h01;
  localparam logic [4:0] GCSR_LVL_CODE1 = 5'h04;
  localparam logic [4:0] GCSR_LVL_CODE2 = 5'h08;
  localparam logic [4:0] GCSR_LVL_CODE3 = 5'h10;

  localparam int GCSR_DATA_W = 8;

  typedef struct packed {
    logic                   write;
    logic                   read;
    logic [7:0]             addr;
    logic [7:0]             wdata;
  } gcsr_reg_req_t;

  typedef struct packed {
    logic [GCSR_DATA_W-1:0] north;
    logic [GCSR_DATA_W-1:0] south;
    logic [GCSR_DATA_W-1:0] west;
    logic [GCSR_DATA_W-1:0] east;
  } gcsr_dataset_t;

  function automatic logic [4:0] gcsr_fifo_level(input logic [1:0] code);
    case (code)
      2'h0:    gcsr_fifo_level = GCSR_LVL_CODE0;
      2'h1:    gcsr_fifo_level = GCSR_LVL_CODE1;
      2'h2:    gcsr_fifo_level = GCSR_LVL_CODE2;
      default: gcsr_fifo_level = GCSR_LVL_CODE3;
    endcase
  endfunction

endpackage

// *** logic/gcsr_smooth.sv ***
/*
  Moving-average smoothing of four-direction gesture samples.
  Assumes one sample_valid pulse per gesture sample cycle.
*/
module gcsr_smooth
  import gcsr_pkg::*;
(
  input  wire logic                    clk_in,
  input  wire logic                    rst_n_in,
  input  wire logic                    sample_valid_in,
  input  wire gcsr_pkg::gcsr_dataset_t sample_in,
  input  wire logic                    enable_in,
  input  wire logic                    window4_in,
  output logic                         valid_out,
  output gcsr_pkg::gcsr_dataset_t      data_out
);
  import gcsr_pkg::*;

  localparam int W = GCSR_DATA_W;

  logic [4*W-1:0] cur;
  logic [4*W-1:0] hist1;
  logic [4*W-1:0] hist2;
  logic [4*W-1:0] hist3;
  logic [4*W-1:0] avg;

  assign cur = sample_in;

  genvar ch;
  generate
    for (ch = 0; ch < 4; ch++)
    begin : g_ch
      logic [W+1:0] sum2;
      logic [W+1:0] sum4;
      assign sum2 = {2'h0, cur[ch*W +: W]} + {2'h0, hist1[ch*W +: W]};
      assign sum4 = sum2 + {2'h0, hist2[ch*W +: W]} + {2'h0, hist3[ch*W +: W]};
      // Two or four samples, plain truncating average
      assign avg[ch*W +: W] = window4_in ? sum4[W+1:2] : sum2[W:1];
    end
  endgenerate

  // History restarts while smoothing is off so the first window is clean
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      hist1 <= '0;
      hist2 <= '0;
      hist3 <= '0;
    end
    else if (!enable_in)
    begin
      hist1 <= cur;
      hist2 <= cur;
      hist3 <= cur;
    end
    else if (sample_valid_in)
    begin
      hist1 <= cur;
      hist2 <= hist1;
      hist3 <= hist2;
    end
  end

  // Moving window: a dataset leaves on every sample cycle
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      valid_out <= 1'b0;
      data_out  <= '0;
    end
    else
    begin
      valid_out <= sample_valid_in;
      if (sample_valid_in)
      begin
        data_out <= enable_in ? gcsr_dataset_t'(avg) : sample_in;
      end
    end
  end

endmodule // gcsr_smooth

// *** logic/gcsr_regs.sv ***
/*
  Gesture configuration and status register bank: FIFO interrupt level,
  pulse count, smoothing filter set-up and sleep-after-interrupt status.
  Assumes register requests arrive decoded from the serial port, one
  cycle each, and that the FIFO reports its fill level every cycle.
*/
module gcsr_regs
  import gcsr_pkg::*;
#(
  parameter int FIFO_LVL_W = 6
)
(
  input  wire logic                    clk_in,
  input  wire logic                    rst_n_in,
  input  wire gcsr_pkg::gcsr_reg_req_t reg_req_in,
  output logic [7:0]                   reg_rdata_out,
  input  wire logic                    sample_valid_in,
  input  wire gcsr_pkg::gcsr_dataset_t sample_in,
  input  wire logic                    gesture_mode_state_in,
  input  wire logic                    gesture_irq_enable_in,
  input  wire logic                    sleep_after_irq_in,
  input  wire logic [FIFO_LVL_W-1:0]   fifo_count_in,
  output logic                         push_valid_out,
  output gcsr_pkg::gcsr_dataset_t      push_data_out,
  output logic                         fifo_irq_out,
  output logic [6:0]                   pulses_per_dataset_out,
  output logic                         osc_enable_out,
  output logic                         sleep_after_irq_flag_out
);
  import gcsr_pkg::*;

  generate
    if (FIFO_LVL_W < 5)
    begin : g_bad_width
      $error("FIFO_LVL_W must hold a count of at least 16");
    end
  endgenerate

  logic [1:0]            fifo_irq_level;
  logic [5:0]            pulses_per_dataset;
  logic                  smoothing_window_size;
  logic                  smoothing_enable;
  logic                  sleep_after_irq_flag;
  logic                  next_sleep_after_irq_flag;
  logic                  wr_fifo_pulse;
  logic                  wr_filter;
  logic                  wr_clear;
  logic                  level_reached;
  logic [FIFO_LVL_W-1:0] level_needed;
  logic                  sample_gated;

  function automatic logic hit(input gcsr_reg_req_t req, input logic [7:0] off);
    hit = req.write && (req.addr == off);
  endfunction

  assign wr_fifo_pulse = hit(reg_req_in, GCSR_OFF_FIFO_PULSE);
  assign wr_filter     = hit(reg_req_in, GCSR_OFF_FILTER);
  assign wr_clear      = hit(reg_req_in, GCSR_OFF_CONTROL)
                         && reg_req_in.wdata[GCSR_CLEAR_BIT];

  // Configuration: only the defined fields are stored
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      fifo_irq_level     <= GCSR_RST_FIFO_LVL;
      pulses_per_dataset <= GCSR_RST_PULSE;
    end
    else if (wr_fifo_pulse)
    begin
      fifo_irq_level     <= reg_req_in.wdata[GCSR_FIFO_LVL_MSB:GCSR_FIFO_LVL_LSB];
      pulses_per_dataset <= reg_req_in.wdata[GCSR_PULSE_MSB:GCSR_PULSE_LSB];
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      smoothing_window_size <= GCSR_RST_WIN_SIZE;
      smoothing_enable      <= GCSR_RST_SMOOTH_EN;
    end
    else if (wr_filter)
    begin
      smoothing_window_size <= reg_req_in.wdata[GCSR_WIN_SIZE_BIT];
      smoothing_enable      <= reg_req_in.wdata[GCSR_SMOOTH_EN_BIT];
      // Bits 7:6 and 3:0 have no storage
    end
  end

  // Pulse count limit sent to the LED driver
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      pulses_per_dataset_out <= 7'h01;
    end
    else
    begin
      pulses_per_dataset_out <= {1'b0, pulses_per_dataset} + 7'h01;
    end
  end

  // FIFO-level interrupt, a level while the count stays at or above target
  assign level_needed  = FIFO_LVL_W'(gcsr_fifo_level(fifo_irq_level));
  assign level_reached = fifo_count_in >= level_needed;

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      fifo_irq_out <= 1'b0;
    end
    else
    begin
      fifo_irq_out <= gesture_irq_enable_in && level_reached;
    end
  end

  // Sleep entry wins over a clear arriving in the same cycle
  always_comb
  begin
    next_sleep_after_irq_flag = sleep_after_irq_flag;
    if (wr_clear)
    begin
      next_sleep_after_irq_flag = 1'b0;
    end
    if (sleep_after_irq_in && fifo_irq_out)
    begin
      next_sleep_after_irq_flag = 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      sleep_after_irq_flag <= 1'b0;
    end
    else
    begin
      sleep_after_irq_flag <= next_sleep_after_irq_flag;
    end
  end

  assign sleep_after_irq_flag_out = sleep_after_irq_flag;
  assign osc_enable_out           = !sleep_after_irq_flag;

  // Samples count only in gesture mode and while the oscillator runs
  assign sample_gated = sample_valid_in && gesture_mode_state_in
                        && !sleep_after_irq_flag;

  gcsr_smooth u_smooth (
    .clk_in          (clk_in),
    .rst_n_in        (rst_n_in),
    .sample_valid_in (sample_gated),
    .sample_in       (sample_in),
    .enable_in       (smoothing_enable),
    .window4_in      (smoothing_window_size),
    .valid_out       (push_valid_out),
    .data_out        (push_data_out)
  );

  // Read data registered one cycle after the read strobe
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      reg_rdata_out <= 8'h00;
    end
    else if (reg_req_in.read)
    begin
      unique case (reg_req_in.addr)
        GCSR_OFF_FIFO_PULSE:
          reg_rdata_out <= {fifo_irq_level, pulses_per_dataset};
        GCSR_OFF_FILTER:
          reg_rdata_out <= {2'h0, smoothing_window_size, smoothing_enable, 4'h0};
        GCSR_OFF_SLEEP_STATUS:
          reg_rdata_out <= {6'h00, sleep_after_irq_flag, 1'b0};
        default:
          reg_rdata_out <= 8'h00;
      endcase
    end
  end

endmodule // gcsr_regs

// *** bench/gcsr_regs_asserts.sv ***
/*
  Port checker for the gesture register bank.
  Assumes it is bound onto gcsr_regs with the same FIFO_LVL_W.
*/
module gcsr_regs_asserts
  import gcsr_pkg::*;
#(
  parameter int FIFO_LVL_W = 6
)
(
  input wire logic                    clk_in,
  input wire logic                    rst_n_in,
  input wire gcsr_pkg::gcsr_reg_req_t reg_req_in,
  input wire logic [7:0]              reg_rdata_out,
  input wire logic                    sample_valid_in,
  input wire logic                    gesture_mode_state_in,
  input wire logic                    gesture_irq_enable_in,
  input wire logic                    sleep_after_irq_in,
  input wire logic [FIFO_LVL_W-1:0]   fifo_count_in,
  input wire logic                    push_valid_out,
  input wire logic                    fifo_irq_out,
  input wire logic [6:0]              pulses_per_dataset_out,
  input wire logic                    osc_enable_out,
  input wire logic                    sleep_after_irq_flag_out
);
  timeunit 1ns;
  timeprecision 1ps;
  import gcsr_pkg::*;

  logic [7:0] cfg1;
  logic [7:0] cfg2;
  int         lvl;
  logic       clr;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  // Shadow of writable fields, reserved bits masked off
  always_ff @(posedge clk_in or negedge rst_n_in)
    if (!rst_n_in)
    begin
      cfg1 <= 8'h00;
      cfg2 <= 8'h00;
    end
    else if (reg_req_in.write && reg_req_in.addr == GCSR_OFF_FIFO_PULSE)
      cfg1 <= reg_req_in.wdata;
    else if (reg_req_in.write && reg_req_in.addr == GCSR_OFF_FILTER)
      cfg2 <= reg_req_in.wdata & 8'h30;
  assign lvl = (cfg1[7:6] == 2'h0) ? 1 : 2 << cfg1[7:6];
  assign clr = reg_req_in.write && reg_req_in.addr == GCSR_OFF_CONTROL && reg_req_in.wdata[0];
  sequence sai_trig_s;
    sleep_after_irq_in && fifo_irq_out;
  endsequence
  sequence rd_status_s;
    reg_req_in.read && reg_req_in.addr == GCSR_OFF_SLEEP_STATUS;
  endsequence
  irq_level_a:
    assert property (fifo_irq_out == $past(gesture_irq_enable_in && int'(fifo_count_in) >= lvl))
    else $error("fifo irq level mismatch");
  // Field register, then output register: the new count shows two edges on
  pulse_count_a:
    assert property (reg_req_in.write && reg_req_in.addr == GCSR_OFF_FIFO_PULSE
      |-> ##2 pulses_per_dataset_out == {1'b0, $past(reg_req_in.wdata[5:0], 2)} + 7'h01)
    else $error("pulse count mismatch");
  sleep_set_a:
    assert property (sai_trig_s |=> sleep_after_irq_flag_out) else $error("sleep flag not set");
  osc_stop_a:
    assert property (osc_enable_out != sleep_after_irq_flag_out) else $error("oscillator state");
  sleep_clear_a:
    assert property (clr && !(sleep_after_irq_in && fifo_irq_out) |=> !sleep_after_irq_flag_out)
    else $error("sleep flag not cleared");
  flag_hold_a:
    assert property (sleep_after_irq_flag_out && !clr |=> sleep_after_irq_flag_out)
    else $error("sleep flag dropped");
  status_read_a:
    assert property (rd_status_s |=> reg_rdata_out == {6'h00, $past(sleep_after_irq_flag_out), 1'b0})
    else $error("status read mismatch");
  filter_read_a:
    assert property (reg_req_in.read && reg_req_in.addr == GCSR_OFF_FILTER
      |=> reg_rdata_out == $past(cfg2)) else $error("filter read mismatch");
  push_gate_a:
    assert property (push_valid_out
      == $past(sample_valid_in && gesture_mode_state_in && !sleep_after_irq_flag_out))
    else $error("push gating mismatch");
endmodule // gcsr_regs_asserts

// *** bench/gcsr_host_model.sv ***
/*
  Host side of the serial register port: single-byte writes and reads.
  Assumes callers wait for reset release first.
*/
module gcsr_host_model
  import gcsr_pkg::*;
(
  input  wire logic               clk_in,
  input  wire logic [7:0]         rdata_in,
  output gcsr_pkg::gcsr_reg_req_t req_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial req_out = '0;
  // Idle fields show inverted values so stale data is never mistaken
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in) req_out <= '{1'b1, 1'b0, a, d};
    @(posedge clk_in) req_out <= '{1'b0, 1'b0, ~a, ~d};
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_in) req_out <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge clk_in) req_out <= '{1'b0, 1'b0, ~a, 8'hFF};
    #1 d = rdata_in;
  endtask
endmodule // gcsr_host_model

// *** bench/testbench.sv ***
/*
  Self-checking bench for the gesture register bank.
  Assumes the host model and checker are compiled before it.
*/
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import gcsr_pkg::*;
  logic          clk_in = 1'b0;
  logic          rst_n_in = 1'b0;
  gcsr_reg_req_t req;
  gcsr_dataset_t smp = '0;
  gcsr_dataset_t pd;
  logic [7:0]    rdata;
  logic [5:0]    cnt = 6'h00;
  logic [6:0]    pulses;
  logic          sv = 1'b0;
  logic          mode = 1'b0;
  logic          en = 1'b0;
  logic          sleep_after_irq = 1'b0;
  logic          pv;
  logic          irq;
  logic          osc;
  logic          flag;
  int            err_total = 0;
  int            comparisons = 0;
  int            cyc = 0;
  gcsr_host_model host (.clk_in(clk_in), .rdata_in(rdata), .req_out(req));
  gcsr_regs #(.FIFO_LVL_W(6)) dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .reg_req_in(req),
    .reg_rdata_out(rdata), .sample_valid_in(sv), .sample_in(smp), .gesture_mode_state_in(mode),
    .gesture_irq_enable_in(en), .sleep_after_irq_in(sleep_after_irq), .fifo_count_in(cnt),
    .push_valid_out(pv), .push_data_out(pd), .fifo_irq_out(irq),
    .pulses_per_dataset_out(pulses), .osc_enable_out(osc), .sleep_after_irq_flag_out(flag));
  initial
  begin
    forever #5 clk_in = ~clk_in;
  end
  always @(posedge clk_in)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      err_total++;
      stop_test();
    end
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      err_total++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic irq_at(input logic [5:0] n, input logic e, input logic x);
    @(posedge clk_in);
    cnt <= n;
    en <= e;
    @(posedge clk_in);
    #1 chk("irq", 32'(x), 32'(irq));
  endtask
  task automatic push(input logic [7:0] v, input logic x, input logic [7:0] e);
    @(posedge clk_in);
    sv <= 1'b1;
    smp <= '{v, v + 8'h10, v + 8'h20, v + 8'h30};
    @(posedge clk_in);
    sv <= 1'b0;
    #1 chk("push", 32'(x), 32'(pv));
    if (x)
      chk("data", {e, e + 8'h10, e + 8'h20, e + 8'h30}, pd);
  endtask
  task automatic t_regs();
    logic [7:0] d;
    logic [7:0] v[2] = '{8'hC5, 8'h3F};
    foreach (v[i])
    begin
      host.wr(GCSR_OFF_FIFO_PULSE, v[i]);
      host.rd(GCSR_OFF_FIFO_PULSE, d);
      chk("cfg1", 32'(v[i]), 32'(d));
      chk("pulses", 32'(v[i][5:0]) + 1, 32'(pulses));
    end
    host.wr(GCSR_OFF_FILTER, 8'hFF);
    host.rd(GCSR_OFF_FILTER, d);
    chk("cfg2", 32'h30, 32'(d));
    host.wr(GCSR_OFF_SLEEP_STATUS, 8'hFF);
    host.rd(GCSR_OFF_SLEEP_STATUS, d);
    chk("status", 32'h00, 32'(d));
    host.rd(8'h20, d);
    chk("unmapped", 32'h00, 32'(d));
  endtask
  task automatic t_irq();
    logic [5:0] lv[4] = '{6'd1, 6'd4, 6'd8, 6'd16};
    for (int c = 0; c < 4; c++)
    begin
      host.wr(GCSR_OFF_FIFO_PULSE, {2'(c), 6'h00});
      irq_at(lv[c] - 6'd1, 1'b1, 1'b0);
      irq_at(lv[c], 1'b1, 1'b1);
      irq_at(6'h3F, 1'b0, 1'b0);
    end
  endtask
  task automatic t_smooth();
    host.wr(GCSR_OFF_FILTER, 8'h00);
    @(posedge clk_in);
    mode <= 1'b1;
    repeat (4) push(8'h20, 1'b1, 8'h20);
    host.wr(GCSR_OFF_FILTER, 8'h10);
    push(8'h11, 1'b1, 8'h18);
    push(8'h33, 1'b1, 8'h22);
    host.wr(GCSR_OFF_FILTER, 8'h30);
    push(8'h05, 1'b1, 8'h1A);
    @(posedge clk_in);
    mode <= 1'b0;
    push(8'h40, 1'b0, 8'h00);
  endtask
  task automatic t_sleep();
    logic [7:0] d;
    host.wr(GCSR_OFF_FIFO_PULSE, 8'h00);
    @(posedge clk_in);
    sleep_after_irq <= 1'b1;
    mode <= 1'b1;
    irq_at(6'h01, 1'b1, 1'b1);
    @(posedge clk_in);
    #1 chk("osc", 32'h0, 32'(osc));
    host.rd(GCSR_OFF_SLEEP_STATUS, d);
    chk("status", 32'h02, 32'(d));
    push(8'h40, 1'b0, 8'h00);
    @(posedge clk_in);
    sleep_after_irq <= 1'b0;
    irq_at(6'h00, 1'b0, 1'b0);
    chk("flag", 32'h1, 32'(flag));
    host.wr(GCSR_OFF_CONTROL, 8'h01);
    @(posedge clk_in);
    #1 chk("flag", 32'h0, 32'(flag));
    chk("osc", 32'h1, 32'(osc));
  endtask
  task automatic stop_test();
    $display("comparisons %0d errors %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (3) @(posedge clk_in);
    rst_n_in <= 1'b1;
    t_regs();
    t_irq();
    t_smooth();
    t_sleep();
    stop_test();
  end
endmodule // testbench
bind gcsr_regs gcsr_regs_asserts #(.FIFO_LVL_W(FIFO_LVL_W)) u_chk (.clk_in, .rst_n_in,
  .reg_req_in, .reg_rdata_out, .sample_valid_in, .gesture_mode_state_in,
  .gesture_irq_enable_in, .sleep_after_irq_in, .fifo_count_in, .push_valid_out,
  .fifo_irq_out, .pulses_per_dataset_out, .osc_enable_out, .sleep_after_irq_flag_out);
